// ---- core/fnd_defs.vh ----
// Purpose : shared constants of the fractional-N divider control block
// Assumes : 10 MHz system clock, AXI4-Lite with 32-bit data
// Notes   : offsets are byte addresses, fields are bit positions in a latch word
`ifndef FND_DEFS_VH
`define FND_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FND_OFF_WORD     8'h00
`define FND_OFF_STATUS   8'h04
`define FND_OFF_LATCH0   8'h40
`define FND_OFF_LATCHN   8'h60

// ----------------------------------------------------------------------
// latch selection and count
// ----------------------------------------------------------------------
`define FND_SEL_LSB      0
`define FND_SEL_MSB      3
`define FND_NUM_LATCH    9
`define FND_SEL_INT      4'h0
`define FND_SEL_PRI      4'h1
`define FND_SEL_AUX      4'h2
`define FND_SEL_MUX      4'h4
`define FND_SEL_REF      4'h5
`define FND_SEL_MODE     4'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FND_INT_LSB      4
`define FND_INT_MSB      19
`define FND_PRI_LSB      4
`define FND_PRI_MSB      27
`define FND_AUXN_LSB     4
`define FND_AUXN_MSB     17
`define FND_AUXM_LSB     18
`define FND_AUXM_MSB     31
`define FND_MUX_LSB      4
`define FND_MUX_MSB      6
`define FND_RCNT_LSB     4
`define FND_RCNT_MSB     13
`define FND_DBL_BIT      14
`define FND_HALVE_BIT    15
`define FND_REFMODE_BIT  30

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define FND_INT_RST      16'h0017
`define FND_AUXM_RST     14'h0002
`define FND_RCNT_RST     10'h001
`define FND_PRI_MOD_LOG2 24
`define FND_RESP_OKAY    2'h0
`define FND_RESP_SLVERR  2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FND_CLK_PS       100000
`define FND_ABP_PS       2600
`define FND_ABP_CYC      ((`FND_ABP_PS + `FND_CLK_PS - 1) / `FND_CLK_PS)

`endif

// ---- core/fnd_divider.v ----
// Purpose : reference path, fractional feedback divider and phase detector
// Assumes : reference and feedback arrive as levels synchronous to clock
// Notes   : configuration arrives as 32-bit words over AXI4-Lite
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "fnd_defs.vh"

module fnd_divider #(
  parameter RCNT_W = 10,
  parameter INT_W  = 16,
  parameter AUX_W  = 14
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        reference_input,
  input  wire        feedback_input,
  output reg         reference_differential,
  output reg         pfd_up,
  output reg         pfd_down,
  output reg         multiplexed_test_output
);

  localparam FW = `FND_PRI_MOD_LOG2;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [31:0]       word_q;
  reg  [31:0]       word_d;
  reg               rd_pend_q;
  reg  [7:0]        rd_addr_q;
  reg  [INT_W-1:0]  int_q;
  reg  [FW-1:0]     pri_q;
  reg  [AUX_W-1:0]  auxn_q;
  reg  [AUX_W-1:0]  auxm_q;
  reg  [2:0]        output_mux_select;
  reg  [RCNT_W-1:0] rcnt_q;
  reg               dbl_q;
  reg               reference_halve_select;
  reg  [INT_W-1:0]  act_int_q;
  reg  [FW-1:0]     act_pri_q;
  reg  [AUX_W-1:0]  act_auxn_q;
  reg  [AUX_W-1:0]  act_auxm_q;
  reg  [RCNT_W-1:0] act_rcnt_q;
  reg               act_dbl_q;
  reg               act_halve_q;
  reg               pend_q;
  reg               ref_last_q;
  reg               halve_tog_q;
  reg  [RCNT_W-1:0] rdiv_q;
  reg               ref_pulse_q;
  reg               fb_last_q;
  reg  [INT_W:0]    ndiv_q;
  reg  [INT_W:0]    nlen_q;
  reg  [FW-1:0]     acc1_q;
  reg  [AUX_W-1:0]  acc2_q;
  reg  [INT_W-1:0]  fb_int_q;
  reg  [FW-1:0]     fb_pri_q;
  reg  [AUX_W-1:0]  fb_auxn_q;
  reg  [AUX_W-1:0]  fb_auxm_q;
  reg               fb_pulse_q;
  reg  [3:0]        abp_q;
  wire [31:0]       mem_rdata;
  wire              wr_go;
  wire [3:0]        wsel;
  wire              latch_go;
  wire              ar_go;
  wire              rd_mapped;
  wire [3:0]        rd_idx;
  wire [3:0]        mem_ridx;
  wire              ref_edge;
  wire              ref_tick;
  wire              fb_edge;
  wire              fb_end;
  wire [AUX_W:0]    acc2_sum;
  wire              carry2;
  wire [AUX_W-1:0]  acc2_next;
  wire [FW:0]       acc1_sum;

  // merge strobed bytes of a write into the previous word
  function [31:0] fnd_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  strb;
    integer i;
    begin
      fnd_merge = old_w;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          fnd_merge[i*8 +: 8] = new_w[i*8 +: 8];
        end
      end
    end
  endfunction

  // zero count means one: the divider never stalls on a zero setting
  function [INT_W:0] fnd_len;
    input [INT_W-1:0] base;
    input             plus_one;
    begin
      fnd_len = {1'b0, base} + {{INT_W{1'b0}}, plus_one};
      if (fnd_len == {(INT_W+1){1'b0}}) begin
        fnd_len = {{INT_W{1'b0}}, 1'b1};
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  // address and data taken together, so no partial write ever lingers
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  always @* begin
    word_d = fnd_merge(word_q, s_axi_wdata, s_axi_wstrb);
  end

  assign wsel     = word_d[`FND_SEL_MSB:`FND_SEL_LSB];
  assign latch_go = wr_go & (s_axi_awaddr == `FND_OFF_WORD)
                    & (wsel < `FND_NUM_LATCH);

  // word register, write response
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      word_q       <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FND_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr == `FND_OFF_WORD) begin
          word_q      <= word_d;
          s_axi_bresp <= `FND_RESP_OKAY;
        end else begin
          s_axi_bresp <= `FND_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration latches
  // ----------------------------------------------------------------------
  // latch zero commits the buffered set, so int itself goes into the active copy straight from the word
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      int_q                  <= `FND_INT_RST;
      pri_q                  <= {FW{1'b0}};
      auxn_q                 <= {AUX_W{1'b0}};
      auxm_q                 <= `FND_AUXM_RST;
      output_mux_select      <= 3'h0;
      rcnt_q                 <= `FND_RCNT_RST;
      dbl_q                  <= 1'b0;
      reference_halve_select <= 1'b0;
      reference_differential <= 1'b0;
    end else if (latch_go) begin
      case (wsel)
        `FND_SEL_INT: int_q <= word_d[`FND_INT_MSB:`FND_INT_LSB];
        `FND_SEL_PRI: pri_q <= word_d[`FND_PRI_MSB:`FND_PRI_LSB];
        `FND_SEL_AUX: begin
          auxn_q <= word_d[`FND_AUXN_MSB:`FND_AUXN_LSB];
          auxm_q <= word_d[`FND_AUXM_MSB:`FND_AUXM_LSB];
        end
        `FND_SEL_MUX: output_mux_select <= word_d[`FND_MUX_MSB:`FND_MUX_LSB];
        `FND_SEL_REF: begin
          rcnt_q                 <= word_d[`FND_RCNT_MSB:`FND_RCNT_LSB];
          dbl_q                  <= word_d[`FND_DBL_BIT];
          reference_halve_select <= word_d[`FND_HALVE_BIT];
        end
        `FND_SEL_MODE: reference_differential <= word_d[`FND_REFMODE_BIT];
        default: ;
      endcase
    end
  end

  // active copies loaded by a latch-zero write
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_int_q   <= `FND_INT_RST;
      act_pri_q   <= {FW{1'b0}};
      act_auxn_q  <= {AUX_W{1'b0}};
      act_auxm_q  <= `FND_AUXM_RST;
      act_rcnt_q  <= `FND_RCNT_RST;
      act_dbl_q   <= 1'b0;
      act_halve_q <= 1'b0;
    end else if (latch_go && wsel == `FND_SEL_INT) begin
      act_int_q   <= word_d[`FND_INT_MSB:`FND_INT_LSB];
      act_pri_q   <= pri_q;
      act_auxn_q  <= auxn_q;
      act_auxm_q  <= auxm_q;
      act_rcnt_q  <= rcnt_q;
      act_dbl_q   <= dbl_q;
      act_halve_q <= reference_halve_select;
    end
  end

  // ----------------------------------------------------------------------
  // readback memory and AXI4-Lite read channel
  // ----------------------------------------------------------------------
  assign rd_idx    = rd_addr_q[5:2];
  assign rd_mapped = (rd_addr_q == `FND_OFF_WORD) || (rd_addr_q == `FND_OFF_STATUS)
                     || ((rd_addr_q >= `FND_OFF_LATCH0) && (rd_addr_q <= `FND_OFF_LATCHN)
                         && (rd_addr_q[1:0] == 2'h0));
  assign ar_go         = s_axi_arvalid & ~rd_pend_q & ~s_axi_rvalid;
  assign s_axi_arready = ar_go;
  // bus address goes straight in on the accept edge, else the answer shows the last word
  assign mem_ridx      = ar_go ? s_axi_araddr[5:2] : rd_idx;

  fnd_latch_mem #(
    .DEPTH (`FND_NUM_LATCH),
    .AW    (4),
    .DW    (32)
  ) u_mem (
    .clock     (clock),
    .wr_en     (latch_go),
    .wr_addr   (wsel),
    .wr_data   (word_d),
    .rd_addr   (mem_ridx),
    .rd_data_q (mem_rdata)
  );

  // one wait cycle lets the memory present its registered data
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_q    <= 1'b0;
      rd_addr_q    <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FND_RESP_OKAY;
    end else begin
      if (ar_go) begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= s_axi_araddr;
      end else if (rd_pend_q) begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_mapped ? `FND_RESP_OKAY : `FND_RESP_SLVERR;
        if (rd_addr_q == `FND_OFF_WORD) begin
          s_axi_rdata <= word_q;
        end else if (rd_addr_q == `FND_OFF_STATUS) begin
          s_axi_rdata <= {13'h0000, pend_q, pfd_down, pfd_up, act_int_q};
        end else if (rd_mapped) begin
          s_axi_rdata <= mem_rdata;
        end else begin
          s_axi_rdata <= 32'h00000000;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // reference path: doubler, halving, reference counter
  // ----------------------------------------------------------------------
  // doubler counts both edges, halving keeps every second tick
  assign ref_edge = act_dbl_q ? (reference_input ^ ref_last_q)
                              : (reference_input & ~ref_last_q);
  assign ref_tick = ref_edge & (~act_halve_q | halve_tog_q);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_last_q  <= 1'b0;
      halve_tog_q <= 1'b0;
      rdiv_q      <= {RCNT_W{1'b0}};
      ref_pulse_q <= 1'b0;
    end else begin
      ref_last_q  <= reference_input;
      ref_pulse_q <= 1'b0;
      if (ref_edge) begin
        halve_tog_q <= ~halve_tog_q;
      end
      if (ref_tick) begin
        // a zero setting behaves as divide by one
        if (rdiv_q + {{(RCNT_W-1){1'b0}}, 1'b1} >= act_rcnt_q) begin
          rdiv_q      <= {RCNT_W{1'b0}};
          ref_pulse_q <= 1'b1;
        end else begin
          rdiv_q <= rdiv_q + {{(RCNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // feedback divider with two-level fractional accumulator
  // ----------------------------------------------------------------------
  assign fb_edge   = feedback_input & ~fb_last_q;
  assign fb_end    = fb_edge & (ndiv_q + {{INT_W{1'b0}}, 1'b1} >= nlen_q);
  assign acc2_sum  = {1'b0, acc2_q} + {1'b0, fb_auxn_q};
  assign carry2    = (acc2_sum >= {1'b0, fb_auxm_q}) && (fb_auxm_q != {AUX_W{1'b0}});
  assign acc2_next = carry2 ? acc2_sum[AUX_W-1:0] - fb_auxm_q : acc2_sum[AUX_W-1:0];
  // modulus 2^24 is the natural wrap of the 24-bit accumulator
  assign acc1_sum  = {1'b0, acc1_q} + {1'b0, fb_pri_q} + {{FW{1'b0}}, carry2};

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fb_last_q  <= 1'b0;
      ndiv_q     <= {(INT_W+1){1'b0}};
      nlen_q     <= fnd_len(`FND_INT_RST, 1'b0);
      acc1_q     <= {FW{1'b0}};
      acc2_q     <= {AUX_W{1'b0}};
      fb_int_q   <= `FND_INT_RST;
      fb_pri_q   <= {FW{1'b0}};
      fb_auxn_q  <= {AUX_W{1'b0}};
      fb_auxm_q  <= `FND_AUXM_RST;
      pend_q     <= 1'b0;
      fb_pulse_q <= 1'b0;
    end else begin
      fb_last_q  <= feedback_input;
      fb_pulse_q <= 1'b0;
      if (fb_end) begin
        ndiv_q     <= {(INT_W+1){1'b0}};
        fb_pulse_q <= 1'b1;
        if (pend_q) begin
          // new ratio starts clean, accumulators cleared
          fb_int_q  <= act_int_q;
          fb_pri_q  <= act_pri_q;
          fb_auxn_q <= act_auxn_q;
          fb_auxm_q <= act_auxm_q;
          acc1_q    <= {FW{1'b0}};
          acc2_q    <= {AUX_W{1'b0}};
          nlen_q    <= fnd_len(act_int_q, 1'b0);
        end else begin
          // zero numerators never carry, so the length stays integer
          acc1_q <= acc1_sum[FW-1:0];
          acc2_q <= acc2_next;
          nlen_q <= fnd_len(fb_int_q, acc1_sum[FW]);
        end
      end else if (fb_edge) begin
        ndiv_q <= ndiv_q + {{INT_W{1'b0}}, 1'b1};
      end
      // set wins over the boundary clear
      if (latch_go && wsel == `FND_SEL_INT) begin
        pend_q <= 1'b1;
      end else if (fb_end) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // phase frequency detector
  // ----------------------------------------------------------------------
  // both outputs stay high together for the antibacklash width, then clear
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pfd_up   <= 1'b0;
      pfd_down <= 1'b0;
      abp_q    <= 4'h0;
    end else if (pfd_up && pfd_down) begin
      if (abp_q + 4'h1 >= `FND_ABP_CYC) begin
        pfd_up   <= 1'b0;
        pfd_down <= 1'b0;
        abp_q    <= 4'h0;
      end else begin
        abp_q <= abp_q + 4'h1;
      end
    end else begin
      if (ref_pulse_q) begin
        pfd_up <= 1'b1;
      end
      if (fb_pulse_q) begin
        pfd_down <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // test output multiplexer
  // ----------------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      multiplexed_test_output <= 1'b0;
    end else begin
      case (output_mux_select)
        3'h0:    multiplexed_test_output <= 1'b0;
        3'h1:    multiplexed_test_output <= 1'b1;
        3'h2:    multiplexed_test_output <= ref_pulse_q;
        3'h3:    multiplexed_test_output <= fb_pulse_q;
        3'h4:    multiplexed_test_output <= pfd_up;
        3'h5:    multiplexed_test_output <= pfd_down;
        3'h6:    multiplexed_test_output <= reference_differential;
        default: multiplexed_test_output <= pend_q;
      endcase
    end
  end

endmodule // fnd_divider

// ---- core/fnd_latch_mem.v ----
// Purpose : storage of the nine configuration latches for readback
// Assumes : one write port, one read port, read data registered
// Notes   : contents are undefined until first written
`timescale 1ns/100ps

module fnd_latch_mem #(
  parameter DEPTH = 9,
  parameter AW    = 4,
  parameter DW    = 32
) (
  input  wire          clock,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_q
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // ----------------------------------------------------------------------
  // write and registered read
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end

endmodule // fnd_latch_mem

// ---- tb/fnd_chk_asserts.sv ----
// Purpose : port checker for the divider control block
// Assumes : one clock, asynchronous active-high reset, full-strobe writes
// Notes   : shadows select and mode latches from bus writes to judge outputs
`timescale 1ns/100ps
`include "fnd_defs.vh"
module fnd_chk (
  input wire        clock,
  input wire        sys_rst,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        reference_differential,
  input wire        pfd_up,
  input wire        pfd_down,
  input wire        multiplexed_test_output
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire        wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        rd_hs = s_axi_arvalid && s_axi_arready;
  logic [1:0] age_q;
  logic [2:0] mux_q;
  logic       ref_q;
  // shadow latches; age lets the registered outputs settle before judging
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      age_q <= 2'h3;
      mux_q <= 3'h0;
      ref_q <= 1'b0;
    end else if (wr_hs && s_axi_awaddr == `FND_OFF_WORD && s_axi_wstrb == 4'hF) begin
      age_q <= 2'h0;
      if (s_axi_wdata[3:0] == `FND_SEL_MUX) mux_q <= s_axi_wdata[6:4];
      if (s_axi_wdata[3:0] == `FND_SEL_MODE) ref_q <= s_axi_wdata[30];
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  sequence settled; age_q == 2'h3; endsequence
  sequence rd_ans; !s_axi_rvalid ##1 s_axi_rvalid; endsequence
  AST_WR_ANS: assert property (wr_hs |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_RD_ANS: assert property (rd_hs |=> rd_ans)
    else $error("read answer not two cycles after address");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  AST_UNMAP: assert property (wr_hs && s_axi_awaddr inside {[8'h08:8'h3C]}
    |=> s_axi_bresp == `FND_RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_ABP: assert property (pfd_up && pfd_down |=> !(pfd_up && pfd_down))
    else $error("detector outputs overlap past the pulse width");
  AST_MUX_LOW: assert property (settled ##0 mux_q == 3'h0 |-> !multiplexed_test_output)
    else $error("test output not low");
  AST_MUX_HIGH: assert property (settled ##0 mux_q == 3'h1 |-> multiplexed_test_output)
    else $error("test output not high");
  AST_REFMODE: assert property (settled |-> reference_differential == ref_q)
    else $error("reference mode differs from its latch bit");
endmodule // fnd_chk
bind fnd_divider fnd_chk i_fnd_chk (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .reference_differential,
  .pfd_up, .pfd_down, .multiplexed_test_output);

// ---- tb/fnd_osc.sv ----
// Purpose : reference and feedback oscillator model for the divider
// Assumes : both sources run free, as real oscillators do
// Notes   : levels change just after the edge so the design samples them cleanly
`timescale 1ns/100ps
module fnd_osc #(
  parameter REF_HALF = 3
) (
  input  wire  clock,
  input  wire  sys_rst,
  output logic reference_input,
  output logic feedback_input
);
  int cnt_q;
  // feedback toggles every cycle, reference every REF_HALF cycles
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 0;
      reference_input <= 1'b0;
      feedback_input <= 1'b0;
    end else begin
      feedback_input <= ~feedback_input;
      if (cnt_q == REF_HALF - 1) begin
        cnt_q <= 0;
        reference_input <= ~reference_input;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule // fnd_osc

// ---- tb/frac_n_divider_ref_path_test.sv ----
// Purpose : self-checking bench for the divider control block
// Assumes : full-strobe bus writes, oscillator model drives both inputs
// Notes   : ratios are measured as input edges per test-output pulse
`timescale 1ns/100ps
`include "fnd_defs.vh"
module frac_n_divider_ref_path_test;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         reference_input, feedback_input, reference_differential;
  wire         pfd_up, pfd_down, multiplexed_test_output;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  int          sels [3] = '{0, 1, 6};
  int          rr [4] = '{1, 6, 5, 1023};
  int          rdb [4] = '{0, 1, 0, 1};
  int          rt [4] = '{0, 0, 1, 0};
  int          fi [3] = '{23, 23, 40};
  int          f1 [3] = '{0, 32'h0080_0000, 32'h0040_0000};
  logic [31:0] lat [9];
  logic [31:0] w;
  logic [31:0] rd_v;
  logic [1:0]  resp;
  fnd_divider i_fnd_divider (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reference_input, .feedback_input, .reference_differential,
    .pfd_up, .pfd_down, .multiplexed_test_output);
  fnd_osc i_fnd_osc (.clock, .sys_rst, .reference_input, .feedback_input);
  always #50 clock = ~clock;
  // hang guard, a little more than twice the longest expected run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      wrap_up;
    end
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // ready and the answer are sampled at the rising edge that completes each channel
  task wr(input [7:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask
  task rd(input [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // serial word to a latch, mirrored in the model
  task put(input [31:0] d);
    wr(`FND_OFF_WORD, d);
    lat[d[3:0]] = d;
    chk(resp, `FND_RESP_OKAY);
  endtask
  // source edges over k test-output pulses; start edge excluded, end included
  task meas(input bit fb, input int k, output int cnt);
    int   r;
    logic pm, ps, s;
    cnt = 0;
    r = -1;
    pm = 1'b1;
    ps = 1'b1;
    while (r < k) begin
      @(posedge clock);
      s = fb ? feedback_input : reference_input;
      if (s && !ps && r >= 0) cnt++;
      if (multiplexed_test_output && !pm) r++;
      pm = multiplexed_test_output;
      ps = s;
    end
  endtask
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h310B));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(`FND_OFF_STATUS);
    chk(rd_v[15:0], `FND_INT_RST);
    chk(multiplexed_test_output, 1'b0);
    rd(8'h08);
    chk(rd_v, 32'h0);
    chk(resp, `FND_RESP_SLVERR);
    wr(8'h3C, $urandom);
    chk(resp, `FND_RESP_SLVERR);
    $display("test reset_map done");
    // random words through latches one to eight, read back, pending until commit
    for (int i = 1; i < 9; i++) begin
      w = $urandom;
      w[3:0] = i[3:0];
      if (i == 2) w[31:18] = 14'h0002 + 14'($urandom_range(16381));
      put(w);
      rd(`FND_OFF_LATCH0 + 8'(4 * i));
      chk(rd_v, lat[i]);
      rd(`FND_OFF_STATUS);
      chk(rd_v[18], 1'b0);
      chk(rd_v[15:0], `FND_INT_RST);
      if (i == 6) chk(reference_differential, w[30]);
    end
    put({12'h0, 16'h0017 + 16'($urandom_range(77)), 4'h0});
    repeat (250) @(posedge clock);
    rd(`FND_OFF_STATUS);
    chk(rd_v[15:0], lat[0][19:4]);
    chk(rd_v[18], 1'b0);
    $display("test latches done");
    // fixed levels and mode bit on the test output
    foreach (sels[j]) begin
      put({25'h0, sels[j][2:0], 4'h4});
      repeat (3) @(posedge clock);
      chk(multiplexed_test_output, sels[j] == 6 ? lat[6][30] : sels[j][0]);
    end
    $display("test mux done");
    // reference path: rising reference edges per reference counter pulse
    put(32'h0000_0024);
    for (int c = 0; c < 4; c++) begin
      put({16'h0, rt[c][0], rdb[c][0], rr[c][9:0], 4'h5});
      put({12'h0, 16'h0017, 4'h0});
      meas(1'b0, 1, n);
      meas(1'b0, 2, n);
      chk(n, 2 * rr[c] * (1 + rt[c]) / (1 + rdb[c]));
    end
    $display("test reference done");
    // feedback path: integer and fractional ratios
    put(32'h0000_0034);
    for (int c = 0; c < 3; c++) begin
      put({4'h0, f1[c][23:0], 4'h1});
      put({14'h0002, 14'h0000, 4'h2});
      put({12'h0, fi[c][15:0], 4'h0});
      meas(1'b1, 1, n);
      meas(1'b1, 4, n);
      chk(n, 4 * fi[c] + ((4 * f1[c]) >> 24));
    end
    $display("test feedback done");
    wrap_up;
  end
endmodule // frac_n_divider_ref_path_test
